// File: core/bst_defs.svh
// Constants for the boundary-scan test access port.
// Assumes inclusion by the package, bst_tap and the bench top module.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH
`define BST_IR_W 4
`define BST_IR_CAPTURE 4'h1
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_HIGHZ 4'h4
`define BST_OP_BYPASS 4'hF
`define BST_ID_W 32
`define BST_ID_VERSION 4'h0
`define BST_ID_PART 16'h0123
`define BST_ID_MAKER 11'h055
`define BST_BSR_W 8
`define BST_TMS_RESET_RUN 5
`endif

// File: core/bst_pkg.sv
// Types for the boundary-scan test access port.
// Assumes bst_defs.svh is on the include path.
`include "bst_defs.svh"
package bst_pkg;
  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR,
    BST_PAUSE_DR, BST_EXIT2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
    BST_SHIFT_IR, BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
  } bst_state_t;
  typedef enum logic [1:0] {BST_SEL_BYPASS, BST_SEL_BSR, BST_SEL_ID} bst_dr_sel_t;
endpackage

// File: core/bst_tap.sv
// Boundary-scan test access port: state machine, instruction register,
// bypass, boundary-scan and identification data registers.
// Assumes test pins arrive asynchronously and are sampled on i_clock.
// TCK must stay high and low for at least three i_clock cycles each.
//
// Notes on behaviour
// - Pins TDI, TMS, TCK, TRST in; TDO out.
// - Five TMS-high edges reach Test-Logic-Reset.
// - Queue operation waits for port reset.
// - State changes on TCK rise, chosen by TMS.
// - Test-Logic-Reset keeps test logic inactive.
// - Run-Test-Idle acts only for suitable instructions.
// - Select states branch to path or onward.
// - Capture-IR loads pattern ending in 01.
// - Shift-IR moves instruction between TDI, TDO.
// - Exit1-IR goes to Pause-IR or Update-IR.
// - Pause-IR holds instruction shift stages.
// - Exit2-IR goes to Shift-IR or Update-IR.
// - Update-IR latches instruction on TCK fall.
// - Capture-DR loads selected data register.
// - Data path states mirror instruction path.
// - Instruction register is four bits, LSB out.
// - Data registers parallel, chosen by instruction.
// - Bypass is one stage, cleared at capture.
// - Bypass shifting leaves function unaffected.
// - Codes 0,1 boundary scan; 2 identification.
// - Code 4 high-Z with bypass; F bypass.
// - Identification is 32 bits, LSB one.
`timescale 1ns/1ns
`include "bst_defs.svh"
module bst_tap (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  input wire logic [`BST_BSR_W-1:0] i_pin_sample,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_queue_enable,
  output logic o_outputs_highz,
  output logic o_extest,
  output logic [`BST_BSR_W-1:0] o_pin_drive,
  output logic o_selftest_run,
  output bst_pkg::bst_state_t o_state
);
  import bst_pkg::*;

  // Two-stage synchronisers for the asynchronous test pins
  logic [1:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic [1:0] trst_sync;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  bst_state_t state;
  bst_state_t next_state;
  logic [`BST_IR_W-1:0] ir_shift;
  logic [`BST_IR_W-1:0] ir_active;
  logic bypass_bit;
  logic [`BST_ID_W-1:0] id_shift;
  logic [`BST_BSR_W-1:0] bsr_shift;
  logic [`BST_BSR_W-1:0] bsr_hold;
  logic [2:0] tms_run;
  logic tap_was_reset;
  bst_dr_sel_t dr_sel;
  logic serial_out;
  logic [`BST_BSR_W-1:0] pin_sync_a;
  logic [`BST_BSR_W-1:0] pin_sync_b;
  logic tms_five;
  logic enter_reset;

  // Identification word, LSB fixed at one; field values are arbitrary
  localparam logic [`BST_ID_W-1:0] ID_WORD = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1};

  // Decode the active instruction to a data register
  function automatic bst_dr_sel_t decode_dr(input logic [`BST_IR_W-1:0] op);
    case (op)
      `BST_OP_EXTEST, `BST_OP_SAMPLE: decode_dr = BST_SEL_BSR;
      `BST_OP_IDCODE: decode_dr = BST_SEL_ID;
      default: decode_dr = BST_SEL_BYPASS; // Covers 4, F and undefined codes
    endcase
  endfunction

  assign dr_sel = decode_dr(ir_active);

  // Only the second stage of each synchroniser is read by logic
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h0;
      trst_sync <= 2'h3; // Idle high, so a system reset alone never reads as a test reset
      tck_prev <= 1'b0;
    end else begin
      tck_sync <= {tck_sync[0], i_tck};
      tms_sync <= {tms_sync[0], i_tms};
      tdi_sync <= {tdi_sync[0], i_tdi};
      trst_sync <= {trst_sync[0], i_trst_n};
      tck_prev <= tck_sync[1];
    end
  end

  // Edge detect on the sampled test clock; TCK period must span several cycles
  assign tck_rise = tck_sync[1] & ~tck_prev;
  assign tck_fall = ~tck_sync[1] & tck_prev;

  // Functional pin levels synchronised per bit; capture reads i_pin_sample
  // directly, so pin_sync_b is never read and no word coherency is promised
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_sync_a <= '0;
      pin_sync_b <= '0;
    end else begin
      pin_sync_a <= i_pin_sample;
      pin_sync_b <= pin_sync_a;
    end
  end

  // Standard next-state table, chosen by TMS
  always_comb begin
    next_state = state;
    unique case (state)
      BST_RESET: next_state = tms_sync[1] ? BST_RESET : BST_IDLE;
      BST_IDLE: next_state = tms_sync[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: next_state = tms_sync[1] ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: next_state = tms_sync[1] ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: next_state = tms_sync[1] ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: next_state = tms_sync[1] ? BST_UPD_DR : BST_PAUSE_DR;
      BST_PAUSE_DR: next_state = tms_sync[1] ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: next_state = tms_sync[1] ? BST_UPD_DR : BST_SHIFT_DR;
      BST_UPD_DR: next_state = tms_sync[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: next_state = tms_sync[1] ? BST_RESET : BST_CAP_IR;
      BST_CAP_IR: next_state = tms_sync[1] ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: next_state = tms_sync[1] ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: next_state = tms_sync[1] ? BST_UPD_IR : BST_PAUSE_IR;
      BST_PAUSE_IR: next_state = tms_sync[1] ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: next_state = tms_sync[1] ? BST_UPD_IR : BST_SHIFT_IR;
      BST_UPD_IR: next_state = tms_sync[1] ? BST_SEL_DR : BST_IDLE;
    endcase
  end

  // State register; TRST low forces Test-Logic-Reset, as do five TMS-high edges
  always_ff @(posedge i_clock) begin
    if (i_rst || !trst_sync[1]) begin
      state <= BST_RESET;
    end else if (tck_rise) begin
      state <= tms_five ? BST_RESET : next_state;
    end
  end

  // Count of consecutive TMS-high rising edges, a guard beside the table
  always_ff @(posedge i_clock) begin
    if (i_rst || !trst_sync[1]) begin
      tms_run <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_sync[1]) begin
        tms_run <= 3'h0;
      end else if (tms_run != 3'(`BST_TMS_RESET_RUN - 1)) begin
        tms_run <= tms_run + 3'h1;
      end
    end
  end

  // Fifth consecutive TMS-high rising edge, whatever the table says
  assign tms_five = tms_sync[1] && (tms_run == 3'(`BST_TMS_RESET_RUN - 1));
  // A clocked arrival in Test-Logic-Reset, by the table or by the guard
  assign enter_reset = tck_rise && (tms_five || next_state == BST_RESET);

  // Queue operation is held off until the tester has reset the port
  // The system reset parks the machine but does not arm the queue: only a test
  // reset or a clocked entry into Test-Logic-Reset does
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tap_was_reset <= 1'b0;
    end else if (!trst_sync[1] || enter_reset) begin
      tap_was_reset <= 1'b1;
    end
  end

  // Instruction shift stages: capture, shift LSB first, hold in pause
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ir_shift <= `BST_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == BST_CAP_IR) begin
        ir_shift <= `BST_IR_CAPTURE;
      end else if (state == BST_SHIFT_IR) begin
        ir_shift <= {tdi_sync[1], ir_shift[`BST_IR_W-1:1]};
      end
    end
  end

  // Active instruction latched on the falling edge in Update-IR; reset picks identification
  always_ff @(posedge i_clock) begin
    if (i_rst || state == BST_RESET) begin
      ir_active <= `BST_OP_IDCODE;
    end else if (tck_fall && state == BST_UPD_IR) begin
      ir_active <= ir_shift;
    end
  end

  // Data registers: only the selected one captures and shifts
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bypass_bit <= 1'b0;
      id_shift <= ID_WORD;
      bsr_shift <= '0;
    end else if (tck_rise) begin
      if (state == BST_CAP_DR) begin
        unique case (dr_sel)
          BST_SEL_BYPASS: bypass_bit <= 1'b0;
          BST_SEL_ID: id_shift <= ID_WORD;
          BST_SEL_BSR: bsr_shift <= i_pin_sample;
        endcase
      end else if (state == BST_SHIFT_DR) begin
        unique case (dr_sel)
          BST_SEL_BYPASS: bypass_bit <= tdi_sync[1];
          BST_SEL_ID: id_shift <= {tdi_sync[1], id_shift[`BST_ID_W-1:1]};
          BST_SEL_BSR: bsr_shift <= {tdi_sync[1], bsr_shift[`BST_BSR_W-1:1]};
        endcase
      end
    end
  end

  // Boundary hold stage updated on the falling edge in Update-DR
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bsr_hold <= '0;
    end else if (tck_fall && state == BST_UPD_DR && dr_sel == BST_SEL_BSR) begin
      bsr_hold <= bsr_shift;
    end
  end

  // Serial source for TDO
  always_comb begin
    serial_out = bypass_bit;
    if (state == BST_SHIFT_IR) begin
      serial_out = ir_shift[0];
    end else if (dr_sel == BST_SEL_ID) begin
      serial_out = id_shift[0];
    end else if (dr_sel == BST_SEL_BSR) begin
      serial_out = bsr_shift[0];
    end
  end

  // TDO moves on the falling edge only
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tdo <= 1'b0;
    end else if (tck_fall) begin
      o_tdo <= serial_out;
    end
  end

  // Enable follows the shift states at the falling edge; a test reset drops it at
  // once, since TCK may be parked high and no falling edge may follow
  always_ff @(posedge i_clock) begin
    if (i_rst || !trst_sync[1]) begin
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo_oe <= (state == BST_SHIFT_IR) || (state == BST_SHIFT_DR);
    end
  end

  // Queue enable; bypass leaves it alone, external test takes the pins away
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_queue_enable <= 1'b0;
    end else begin
      o_queue_enable <= tap_was_reset && (ir_active != `BST_OP_EXTEST);
    end
  end

  // Test-mode controls; high-Z and external test inactive in Test-Logic-Reset, pin drive always follows the hold stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_outputs_highz <= 1'b0;
      o_extest <= 1'b0;
      o_pin_drive <= '0;
      o_selftest_run <= 1'b0;
    end else begin
      o_outputs_highz <= (state != BST_RESET) && (ir_active == `BST_OP_HIGHZ);
      o_extest <= (state != BST_RESET) && (ir_active == `BST_OP_EXTEST);
      o_pin_drive <= bsr_hold;
      o_selftest_run <= 1'b0; // No self-test instruction is defined, so idle stays quiet
    end
  end

  // State mirror for observation, one clock behind the machine
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_state <= BST_RESET;
    end else begin
      o_state <= state;
    end
  end
endmodule // bst_tap

// File: dv/bst_tap_checker.sv
// Checker for the test access port, bound to bst_tap.
// Assumes synchronised test pins, o_state one clock behind.
`timescale 1ns/1ns
module bst_tap_checker
  import bst_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic o_queue_enable,
  input wire logic o_extest,
  input wire logic o_selftest_run,
  input wire bst_state_t o_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Test reset held past the synchronisers
  sequence s_trst;
    !i_trst_n [*6];
  endsequence
  sequence s_left(bst_state_t s);
    $changed(o_state) && $past(o_state) == s;
  endsequence
  property p_rst;
    disable iff (1'b0) i_rst |=> o_state == BST_RESET && !o_tdo_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not applied");
  property p_trst;
    s_trst |-> o_state == BST_RESET && !o_tdo_oe;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_oe;
    $rose(o_tdo_oe) |-> o_state inside {BST_SHIFT_IR, BST_SHIFT_DR};
  endproperty
  a_oe: assert property (p_oe) else $error("serial out driven off shift");
  property p_sel;
    s_left(BST_SEL_IR) |-> o_state inside {BST_CAP_IR, BST_RESET};
  endproperty
  a_sel: assert property (p_sel) else $error("bad select branch");
  property p_ex1;
    s_left(BST_EXIT1_IR) |-> o_state inside {BST_PAUSE_IR, BST_UPD_IR, BST_RESET};
  endproperty
  a_ex1: assert property (p_ex1) else $error("bad exit1 branch");
  property p_ex2;
    s_left(BST_EXIT2_IR) |-> o_state inside {BST_SHIFT_IR, BST_UPD_IR, BST_RESET};
  endproperty
  a_ex2: assert property (p_ex2) else $error("bad exit2 branch");
  // Serial out moves only after a falling test clock
  property p_tdo;
    $changed(o_tdo) |-> !$past(i_tck, 2);
  endproperty
  a_tdo: assert property (p_tdo) else $error("serial out moved on rise");
  property p_ext;
    o_extest && $past(o_extest) |-> !o_queue_enable && !o_selftest_run;
  endproperty
  a_ext: assert property (p_ext) else $error("queue live in external test");
endmodule // bst_tap_checker

// File: dv/bst_tester.sv
// Tester model: drives the test pins, samples serial out.
// Assumes one test clock spans 8 cycles of i_clock.
`timescale 1ns/1ns
module bst_tester (
  input wire logic i_clock,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  // Fall, hold low 4 cycles, sample just before rise is seen
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clock);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clock);
    o_tck <= 1'b1;
    #1 tdo = i_tdo;
    repeat (3) @(posedge i_clock);
  endtask
  // Five TMS-high clocks; the system reset parks the port but does not arm the queue
  task automatic tap_reset();
    logic t;
    repeat (5) step(1'b1, ~o_tdi, t);
  endtask
  // Clock stands low between frames, data no longer valid
  task automatic rest();
    @(posedge i_clock);
    o_tck <= 1'b0;
    o_tdi <= ~o_tdi;
  endtask
  task automatic trst();
    @(posedge i_clock);
    o_trst_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    o_trst_n <= 1'b1;
  endtask
endmodule // bst_tester

// File: dv/boundary_scan_tap_tb_top.sv
// Self-checking bench for bst_tap with a tester model.
// Assumes bst_defs.svh on the include path.
`timescale 1ns/1ns
`include "bst_defs.svh"
module boundary_scan_tap_tb_top;
  import bst_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_tck, i_tms, i_tdi, i_trst_n, o_tdo, o_tdo_oe, o_queue_enable;
  logic o_outputs_highz, o_extest, o_selftest_run;
  logic [7:0] i_pin_sample = 8'hA5;
  logic [7:0] o_pin_drive;
  bst_state_t o_state;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] got;
  logic [3:0] cap;
  bst_tap u_bst_tap (.i_clock, .i_rst, .i_tck, .i_tms, .i_tdi, .i_trst_n, .i_pin_sample, .o_tdo,
    .o_tdo_oe, .o_queue_enable, .o_outputs_highz, .o_extest, .o_pin_drive, .o_selftest_run, .o_state);
  bst_tester u_bst_tester (.i_clock, .i_tdo(o_tdo), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .o_trst_n(i_trst_n));
  initial forever #10 i_clock = ~i_clock;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Step TMS bits LSB first with data low
  task automatic walk(input int k, input logic [7:0] tms);
    logic t;
    for (int i = 0; i < k; i++) u_bst_tester.step(tms[i], 1'b0, t);
  endtask
  task automatic settle();
    repeat (4) @(posedge i_clock);
    #1;
  endtask
  // Instruction scan with a pause after two bits, ends in idle
  task automatic ir_load(input logic [3:0] code);
    walk(4, 8'h03);
    for (int i = 0; i < 4; i++) begin
      u_bst_tester.step(i == 1 || i == 3, code[i], cap[i]);
      chk(o_tdo_oe, 1);
      if (i == 1) begin
        walk(2, 8'h00);
        chk(o_tdo_oe, 0);
        walk(2, 8'h01);
      end
    end
    walk(2, 8'h01);
    settle();
    chk(cap, `BST_IR_CAPTURE);
  endtask
  task automatic dr_scan(input int n, input logic [31:0] din);
    got = '0;
    walk(3, 8'h01);
    for (int i = 0; i < n; i++) u_bst_tester.step(i == n - 1, din[i], got[i]);
    walk(2, 8'h01);
    settle();
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    settle();
    chk(o_queue_enable, 0);
    u_bst_tester.tap_reset();
    settle();
    chk(o_state, BST_RESET);
    chk(o_queue_enable, 1);
    walk(1, 8'h00);
    chk(o_selftest_run, 0);
    dr_scan(32, 32'h0);
    chk(got, {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1});
    ir_load(`BST_OP_BYPASS);
    dr_scan(4, 32'hB);
    chk(got, 32'h6);
    chk(o_queue_enable, 1);
    // High impedance code, then an undefined code
    for (int c = 4; c < 8; c += 3) begin
      ir_load(c[3:0]);
      chk(o_outputs_highz, c == 4);
      dr_scan(2, 32'h3);
      chk(got, 32'h2);
    end
    ir_load(`BST_OP_SAMPLE);
    dr_scan(8, 32'h3C);
    chk(got, 32'hA5);
    chk(o_pin_drive, 32'h3C);
    ir_load(`BST_OP_EXTEST);
    chk(o_extest, 1);
    chk(o_queue_enable, 0);
    walk(4, 8'h01);
    chk(o_tdo_oe, 1);
    u_bst_tester.trst();
    settle();
    chk(o_state, BST_RESET);
    chk(o_tdo_oe, 0);
    chk(o_extest, 0);
    u_bst_tester.rest();
    print_verdict();
  end
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule // boundary_scan_tap_tb_top
bind bst_tap bst_tap_checker u_bst_tap_checker (.i_clock, .i_rst, .i_tck, .i_trst_n, .o_tdo, .o_tdo_oe,
  .o_queue_enable, .o_extest, .o_selftest_run, .o_state);
